// File: verilog/pmsc_top.sv
// Power management status/control and system options register bank.
// Assumes a synchronous APB master on clk; rst_n is the power-on reset,
// sys_reset_pulse a one-cycle non-power-on reset from same-clock logic.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`include "pmsc_regs.svh"

// Contract
// - Detect flag sets on a detect event only while detection is enabled.
// - Writing one to detect clear clears the flag; clear reads zero.
// - Detect interrupt requested while flag and interrupt enable are set.
// - Set flag with reset enable and detection enabled forces reset.
// - Stop enable decides whether detection runs in stop mode.
// - Logic enable switches detection on and gates stop and reset enables, not interrupt enable.
// - Bit 0 of control one enables the reference buffer.
// - Warning flag is sticky while or since the warning was present.
// - Warning clear clears the flag only if no warning is present.
// - Warning flag also sets after reset if supply is already low.
// - Detect trip select writes once after power-on, kept otherwise.
// - Warning trip select survives all non-power-on resets.
// - Deep stop exit flag sets on leaving partial power down stop.
// - Writing one to deep stop clear clears the flag; reads zero.
// - Deep stop select takes only the first write after reset.
// - Watchdog clock select is write-once; one selects bus clock.
// - Timer routing zero shares the interrupt-pin clock to all timers.
module pmsc_top
  import pmsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sys_reset_pulse,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic undervolt_event,
  input wire logic supply_warning_present,
  input wire logic stop_mode_active,
  input wire logic deep_stop_exit_pulse,
  input wire logic shared_timer_ext_clock,
  input wire logic timer_one_ext_clock,
  input wire logic timer_two_ext_clock,
  output logic undervolt_irq,
  output logic undervolt_reset_req,
  output logic undervolt_detect_active,
  output logic undervolt_trip_select,
  output logic warning_trip_select,
  output logic deep_stop_select,
  output logic reference_buffer_enable,
  output logic watchdog_bus_clock_select,
  output logic timer_clock_routing,
  output logic [2:0] timer_ext_clock
);
  pmsc_state_t cur_q;
  pmsc_state_t nxt_d;

  logic acc;
  logic hit_one;
  logic hit_two;
  logic hit_opt;
  logic mapped;
  logic wr;
  logic [7:0] wb;
  logic [7:0] rd_one;
  logic [7:0] rd_two;
  logic [7:0] rd_opt;
  logic [2:0] tclk_pins;
  logic w_opt;
  // Reset images, so each field takes exactly its own bit
  localparam logic [7:0] rst_one = `PMSC_RST_CTRL_ONE;
  localparam logic [7:0] rst_two = `PMSC_RST_CTRL_TWO;
  localparam logic [7:0] rst_opt = `PMSC_RST_OPTS_TWO;

  assign hit_one = paddr == `PMSC_OFF_CTRL_ONE;
  assign hit_two = paddr == `PMSC_OFF_CTRL_TWO;
  assign hit_opt = paddr == `PMSC_OFF_OPTS_TWO;
  assign mapped = hit_one | hit_two | hit_opt;
  assign acc = psel & penable;
  // Only the low lane carries register bits
  assign wr = acc & pwrite & mapped & pstrb[0];
  assign wb = pwdata[7:0];
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Clear bits and the reserved bit always read back as zero
  assign rd_one = {cur_q.uv_flag, 1'b0, cur_q.uv_irq_en,
                   cur_q.uv_rst_en, cur_q.uv_stop_en,
                   cur_q.uv_logic_en, 1'b0, cur_q.ref_buf_en};
  assign rd_two = {cur_q.warn_flag, 1'b0, cur_q.uv_trip,
                   cur_q.warn_trip, cur_q.ds_flag, 1'b0,
                   1'b0, cur_q.ds_sel};
  assign rd_opt = {cur_q.wdog_clk, 3'h0, cur_q.tmr_route, 3'h0};
  // Bit order follows the timers: first, second, then the shared pin third
  assign tclk_pins = {shared_timer_ext_clock, timer_two_ext_clock,
                      timer_one_ext_clock};

  always_comb
  begin
    logic det_run;
    logic w1;
    logic w2;
    logic wo;
    det_run = 1'b0;
    w1 = wr & hit_one;
    w2 = wr & hit_two;
    wo = wr & hit_opt;
    nxt_d = cur_q;
    // Event, warning and timer clock pins cross two flops; stop mode and deep stop exit are read directly
    nxt_d.s1 = '{uv_ev: undervolt_event, warn: supply_warning_present,
                 tclk: tclk_pins};
    nxt_d.s2 = cur_q.s1;

    // Detection runs when enabled, and in stop only if allowed
    det_run = cur_q.uv_logic_en &
              (~stop_mode_active | cur_q.uv_stop_en);

    if (w1)
    begin
      nxt_d.uv_irq_en = wb[`PMSC_B_UV_IRQ_EN];
      nxt_d.uv_rst_en = wb[`PMSC_B_UV_RST_EN];
      nxt_d.uv_stop_en = wb[`PMSC_B_UV_STOP_EN];
      nxt_d.uv_logic_en = wb[`PMSC_B_UV_LOGIC_EN];
      nxt_d.ref_buf_en = wb[`PMSC_B_REF_BUF_EN];
      if (wb[`PMSC_B_UV_CLEAR])
        nxt_d.uv_flag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (cur_q.s2.uv_ev & det_run)
      nxt_d.uv_flag = 1'b1;

    if (w2)
    begin
      nxt_d.warn_trip = wb[`PMSC_B_WARN_TRIP];
      if (!cur_q.uv_trip_once)
      begin
        nxt_d.uv_trip = wb[`PMSC_B_UV_TRIP];
        nxt_d.uv_trip_once = 1'b1;
      end
      if (!cur_q.ds_sel_once)
      begin
        nxt_d.ds_sel = wb[`PMSC_B_DS_SELECT];
        nxt_d.ds_sel_once = 1'b1;
      end
      if (wb[`PMSC_B_WARN_CLEAR])
        nxt_d.warn_flag = 1'b0;
      if (wb[`PMSC_B_DS_CLEAR])
        nxt_d.ds_flag = 1'b0;
    end
    // A present warning keeps the flag set, also right after reset
    if (cur_q.s2.warn)
      nxt_d.warn_flag = 1'b1;
    if (deep_stop_exit_pulse)
      nxt_d.ds_flag = 1'b1;

    if (wo)
    begin
      nxt_d.tmr_route = wb[`PMSC_B_TMR_ROUTE];
      if (!cur_q.wdog_once)
      begin
        nxt_d.wdog_clk = wb[`PMSC_B_WDOG_CLK];
        nxt_d.wdog_once = 1'b1;
      end
    end

    nxt_d.irq = cur_q.uv_flag & cur_q.uv_irq_en;
    nxt_d.rst_req = cur_q.uv_flag & cur_q.uv_rst_en &
                    cur_q.uv_logic_en;
    nxt_d.det_active = det_run;
    // Routing zero hands the shared pin clock to every timer
    nxt_d.tmr_clk = cur_q.tmr_route ? cur_q.s2.tclk
                                    : {3{cur_q.s2.tclk[2]}};

    // Read data is captured in the setup cycle for the access phase
    if (psel & ~penable)
      nxt_d.rdata = {24'h000000, hit_one ? rd_one
                                  : hit_two ? rd_two
                                  : hit_opt ? rd_opt : 8'h00};

    // Non-power-on reset: trip selects and the trip write-once lock stay
    if (sys_reset_pulse)
    begin
      nxt_d.uv_flag = 1'b0;
      nxt_d.uv_irq_en = rst_one[`PMSC_B_UV_IRQ_EN];
      nxt_d.uv_rst_en = rst_one[`PMSC_B_UV_RST_EN];
      nxt_d.uv_stop_en = rst_one[`PMSC_B_UV_STOP_EN];
      nxt_d.uv_logic_en = rst_one[`PMSC_B_UV_LOGIC_EN];
      nxt_d.ref_buf_en = rst_one[`PMSC_B_REF_BUF_EN];
      nxt_d.warn_flag = 1'b0;
      nxt_d.ds_flag = 1'b0;
      nxt_d.ds_sel = rst_two[`PMSC_B_DS_SELECT];
      nxt_d.ds_sel_once = 1'b0;
      nxt_d.wdog_clk = rst_opt[`PMSC_B_WDOG_CLK];
      nxt_d.wdog_once = 1'b0;
      nxt_d.tmr_route = rst_opt[`PMSC_B_TMR_ROUTE];
      nxt_d.irq = 1'b0;
      nxt_d.rst_req = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cur_q <= '0;
    else
      cur_q <= nxt_d;
  end

  assign prdata = cur_q.rdata;
  assign undervolt_irq = cur_q.irq;
  assign undervolt_reset_req = cur_q.rst_req;
  assign undervolt_detect_active = cur_q.det_active;
  assign undervolt_trip_select = cur_q.uv_trip;
  assign warning_trip_select = cur_q.warn_trip;
  assign deep_stop_select = cur_q.ds_sel;
  assign reference_buffer_enable = cur_q.ref_buf_en;
  assign watchdog_bus_clock_select = cur_q.wdog_clk;
  assign timer_clock_routing = cur_q.tmr_route;
  assign timer_ext_clock = cur_q.tmr_clk;

  logic w_one;
  logic w_two;
  assign w_one = wr & hit_one;
  assign w_two = wr & hit_two;
  assign w_opt = wr & hit_opt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  flag_set_a: assert property (
    cur_q.s2.uv_ev && cur_q.uv_logic_en && !stop_mode_active
    && !sys_reset_pulse |=> cur_q.uv_flag)
    else $error("detect flag not set by event");
  flag_hold_off_a: assert property (
    !cur_q.uv_logic_en && !cur_q.uv_flag && !w_one |=> !cur_q.uv_flag)
    else $error("detect flag set while detection off");
  ack_clear_a: assert property (
    w_one && wb[`PMSC_B_UV_CLEAR] && !cur_q.s2.uv_ev |=> !cur_q.uv_flag)
    else $error("detect clear did not clear flag");
  stop_gate_a: assert property (
    stop_mode_active && !cur_q.uv_stop_en && !cur_q.uv_flag && !w_one
    |=> !cur_q.uv_flag)
    else $error("detect flag set in stop without stop enable");
  irq_level_a: assert property (
    !sys_reset_pulse |=> undervolt_irq == $past(cur_q.uv_flag
                                               && cur_q.uv_irq_en))
    else $error("interrupt level does not follow flag and enable");
  reset_req_a: assert property (
    cur_q.uv_flag && cur_q.uv_rst_en && cur_q.uv_logic_en
    && !sys_reset_pulse |=> undervolt_reset_req)
    else $error("reset request missing");
  read_zero_a: assert property (
    psel && !penable |=> prdata[6] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("clear bit read back nonzero");
  warn_sticky_a: assert property (
    cur_q.s2.warn && !sys_reset_pulse |=> cur_q.warn_flag [*1] ##0
    cur_q.warn_flag)
    else $error("warning flag not set while warning present");
  warn_ack_a: assert property (
    w_two && wb[`PMSC_B_WARN_CLEAR] && !cur_q.s2.warn
    |=> !cur_q.warn_flag)
    else $error("warning clear failed");
  ds_flag_a: assert property (
    deep_stop_exit_pulse && !sys_reset_pulse |=> cur_q.ds_flag)
    else $error("deep stop exit flag not set");
  ds_once_a: assert property (
    cur_q.ds_sel_once && !sys_reset_pulse |=> $stable(deep_stop_select))
    else $error("deep stop select changed after first write");
  trip_once_a: assert property (
    cur_q.uv_trip_once |=> $stable(undervolt_trip_select))
    else $error("trip select changed after first write");
  wdog_once_a: assert property (
    cur_q.wdog_once && !sys_reset_pulse
    |=> $stable(watchdog_bus_clock_select))
    else $error("watchdog clock select changed twice");
  tmr_share_a: assert property (
    !cur_q.tmr_route && !sys_reset_pulse
    |=> timer_ext_clock == {3{$past(cur_q.s2.tclk[2])}})
    else $error("shared timer clock not routed to all timers");

  // Flags hold until their own clear or a reset takes them
  uv_keep_a: assert property (
    cur_q.uv_flag && !(w_one && wb[`PMSC_B_UV_CLEAR]) && !sys_reset_pulse
    |=> cur_q.uv_flag)
    else $error("detect flag dropped without clear");
  warn_keep_a: assert property (
    cur_q.warn_flag && !(w_two && wb[`PMSC_B_WARN_CLEAR])
    && !sys_reset_pulse |=> cur_q.warn_flag)
    else $error("warning flag dropped without clear");
  ds_keep_a: assert property (
    cur_q.ds_flag && !(w_two && wb[`PMSC_B_DS_CLEAR])
    && !sys_reset_pulse |=> cur_q.ds_flag)
    else $error("deep stop exit flag dropped without clear");
  ds_ack_a: assert property (
    w_two && wb[`PMSC_B_DS_CLEAR] && !deep_stop_exit_pulse
    |=> !cur_q.ds_flag)
    else $error("deep stop clear did not clear flag");

  // Detection gating as seen on the outputs
  stop_run_a: assert property (
    stop_mode_active && cur_q.uv_stop_en && cur_q.uv_logic_en
    && cur_q.s2.uv_ev && !sys_reset_pulse |=> cur_q.uv_flag)
    else $error("detect flag not set in stop with stop enable");
  det_view_a: assert property (
    1'b1 |=> undervolt_detect_active == $past(cur_q.uv_logic_en
             && (!stop_mode_active || cur_q.uv_stop_en)))
    else $error("detect active does not follow enables");
  det_off_a: assert property (
    !cur_q.uv_logic_en |=> !undervolt_detect_active)
    else $error("detection active while logic enable is off");
  rst_off_a: assert property (
    !cur_q.uv_logic_en |=> !undervolt_reset_req)
    else $error("reset request while logic enable is off");
  irq_off_a: assert property (
    !cur_q.uv_flag |=> !undervolt_irq)
    else $error("interrupt without detect flag");

  // Clear strobes and unused bits never show in read data
  rd_one_zero_a: assert property (
    psel && !penable && hit_one |=> prdata[`PMSC_B_UV_CLEAR] == 1'b0
    && prdata[`PMSC_B_RSVD_ONE] == 1'b0)
    else $error("control one clear or reserved bit read nonzero");
  rd_two_zero_a: assert property (
    psel && !penable && hit_two |=> prdata[`PMSC_B_DS_CLEAR] == 1'b0
    && prdata[1] == 1'b0)
    else $error("control two clear or unused bit read nonzero");

  // Register writes and the write-once locks
  ref_buf_a: assert property (
    w_one && !sys_reset_pulse
    |=> reference_buffer_enable == $past(wb[`PMSC_B_REF_BUF_EN]))
    else $error("reference buffer enable not written");
  ref_hold_a: assert property (
    !w_one && !sys_reset_pulse |=> $stable(reference_buffer_enable))
    else $error("reference buffer enable changed without write");
  warn_trip_a: assert property (
    w_two |=> warning_trip_select == $past(wb[`PMSC_B_WARN_TRIP]))
    else $error("warning trip select not written");
  warn_sel_keep_a: assert property (
    !w_two |=> $stable(warning_trip_select))
    else $error("warning trip select changed without write");
  trip_first_a: assert property (
    w_two && !cur_q.uv_trip_once
    |=> undervolt_trip_select == $past(wb[`PMSC_B_UV_TRIP]))
    else $error("first trip select write not taken");
  trip_keep_a: assert property (
    !w_two |=> $stable(undervolt_trip_select))
    else $error("trip select changed without write");
  ds_first_a: assert property (
    w_two && !cur_q.ds_sel_once && !sys_reset_pulse
    |=> deep_stop_select == $past(wb[`PMSC_B_DS_SELECT]))
    else $error("first deep stop select write not taken");
  ds_unlock_a: assert property (
    sys_reset_pulse |=> !cur_q.ds_sel_once)
    else $error("deep stop select lock kept through reset");
  wdog_first_a: assert property (
    w_opt && !cur_q.wdog_once && !sys_reset_pulse
    |=> watchdog_bus_clock_select == $past(wb[`PMSC_B_WDOG_CLK]))
    else $error("first watchdog clock write not taken");
  wdog_unlock_a: assert property (
    sys_reset_pulse |=> !cur_q.wdog_once)
    else $error("watchdog clock lock kept through reset");
  route_wr_a: assert property (
    w_opt && !sys_reset_pulse
    |=> timer_clock_routing == $past(wb[`PMSC_B_TMR_ROUTE]))
    else $error("timer routing not written");
  tmr_own_a: assert property (
    cur_q.tmr_route |=> timer_ext_clock == $past(cur_q.s2.tclk))
    else $error("own timer clocks not routed");
endmodule : pmsc_top

// File: pkg/pmsc_regs.svh
// Register offsets, bit positions and reset values of the power bank.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH
`define PMSC_ADDR_W 12
`define PMSC_OFF_CTRL_ONE 12'h000
`define PMSC_OFF_CTRL_TWO 12'h004
`define PMSC_OFF_OPTS_TWO 12'h008
// Control one fields
`define PMSC_B_UV_FLAG 7
`define PMSC_B_UV_CLEAR 6
`define PMSC_B_UV_IRQ_EN 5
`define PMSC_B_UV_RST_EN 4
`define PMSC_B_UV_STOP_EN 3
`define PMSC_B_UV_LOGIC_EN 2
`define PMSC_B_RSVD_ONE 1
`define PMSC_B_REF_BUF_EN 0
// Control two fields
`define PMSC_B_WARN_FLAG 7
`define PMSC_B_WARN_CLEAR 6
`define PMSC_B_UV_TRIP 5
`define PMSC_B_WARN_TRIP 4
`define PMSC_B_DS_FLAG 3
`define PMSC_B_DS_CLEAR 2
`define PMSC_B_DS_SELECT 0
// Options two fields
`define PMSC_B_WDOG_CLK 7
`define PMSC_B_TMR_ROUTE 3
// Reset values
`define PMSC_RST_CTRL_ONE 8'h00
`define PMSC_RST_CTRL_TWO 8'h00
`define PMSC_RST_OPTS_TWO 8'h00
`endif

// File: pkg/pmsc_pkg.sv
// Types of the power management register bank.
// Assumes pmsc_regs.svh for all numeric constants.
package pmsc_pkg;
  typedef struct packed {
    logic uv_ev;
    logic warn;
    logic [2:0] tclk;
  } pmsc_pins_t;

  typedef struct packed {
    pmsc_pins_t s1;
    pmsc_pins_t s2;
    logic uv_flag;
    logic uv_irq_en;
    logic uv_rst_en;
    logic uv_stop_en;
    logic uv_logic_en;
    logic ref_buf_en;
    logic warn_flag;
    logic uv_trip;
    logic uv_trip_once;
    logic warn_trip;
    logic ds_flag;
    logic ds_sel;
    logic ds_sel_once;
    logic wdog_clk;
    logic wdog_once;
    logic tmr_route;
    logic irq;
    logic rst_req;
    logic det_active;
    logic [2:0] tmr_clk;
    logic [31:0] rdata;
  } pmsc_state_t;
endpackage : pmsc_pkg

// File: testbench/pmsc_top_tb.sv
// Self-checking bench of the power management register bank.
// Assumes pmsc_top with a zero-wait APB slave; the bench drives all ports.
`include "pmsc_regs.svh"
module pmsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] a_one = `PMSC_OFF_CTRL_ONE;
  localparam logic [11:0] a_two = `PMSC_OFF_CTRL_TWO;
  localparam logic [11:0] a_opt = `PMSC_OFF_OPTS_TWO;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sys_reset_pulse = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`PMSC_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic undervolt_event = 1'b0;
  logic supply_warning_present = 1'b0;
  logic stop_mode_active = 1'b0;
  logic deep_stop_exit_pulse = 1'b0;
  logic shared_timer_ext_clock = 1'b0;
  logic timer_one_ext_clock = 1'b0;
  logic timer_two_ext_clock = 1'b0;
  logic undervolt_irq, undervolt_reset_req, undervolt_detect_active;
  logic undervolt_trip_select, warning_trip_select, deep_stop_select;
  logic reference_buffer_enable, watchdog_bus_clock_select;
  logic timer_clock_routing;
  logic [2:0] timer_ext_clock;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] rv;
  logic ev;
  logic [31:0] v;

  always #4 clk = ~clk;

  pmsc_top i_pmsc_top (.clk, .rst_n, .sys_reset_pulse, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .undervolt_event, .supply_warning_present, .stop_mode_active,
    .deep_stop_exit_pulse, .shared_timer_ext_clock, .timer_one_ext_clock,
    .timer_two_ext_clock, .undervolt_irq, .undervolt_reset_req,
    .undervolt_detect_active, .undervolt_trip_select, .warning_trip_select,
    .deep_stop_select, .reference_buffer_enable, .watchdog_bus_clock_select,
    .timer_clock_routing, .timer_ext_clock);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Entered right after a rising edge; ends one idle edge after release
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    @(posedge clk);
    while (pready !== 1'b1 && i < 16)
    begin
      i++;
      @(posedge clk);
    end
    if (pready !== 1'b1)
    begin
      failures++;
      give_verdict();
    end
    else
    begin
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rd

  task pulse_uv;
    undervolt_event <= 1'b1;
    cyc(2);
    undervolt_event <= 1'b0;
    cyc(4);
  endtask : pulse_uv

  function automatic logic [2:0] exp_tmr(input logic r, input logic s,
    input logic t1, input logic t2);
    return r ? {s, t2, t1} : {3{s}};
  endfunction : exp_tmr

  initial
  begin
    void'($urandom(32'h7DDBE0E9));
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    rd(a_one, 32'h0);
    rd(a_two, 32'h0);
    rd(a_opt, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(ev, 1'b1);
    // Detect path: flag, level interrupt, reset request, clear
    apb(1'b1, a_one, 32'h3D);
    rd(a_one, 32'h3D);
    chk(reference_buffer_enable, 1'b1);
    chk(undervolt_detect_active, 1'b1);
    pulse_uv();
    rd(a_one, 32'hBD);
    chk(undervolt_irq, 1'b1);
    chk(undervolt_reset_req, 1'b1);
    cyc(4);
    chk(undervolt_irq, 1'b1);
    apb(1'b1, a_one, 32'h7D);
    cyc(2);
    chk(undervolt_irq, 1'b0);
    rd(a_one, 32'h3D);
    // Polling only, no reset: flag sets, nothing is requested
    apb(1'b1, a_one, 32'h04);
    pulse_uv();
    chk(undervolt_irq, 1'b0);
    chk(undervolt_reset_req, 1'b0);
    rd(a_one, 32'h84);
    // Logic off gates the flag and the reset request
    apb(1'b1, a_one, 32'h70);
    pulse_uv();
    rd(a_one, 32'h30);
    chk(undervolt_reset_req, 1'b0);
    apb(1'b1, a_one, 32'h04);
    stop_mode_active <= 1'b1;
    cyc(2);
    chk(undervolt_detect_active, 1'b0);
    pulse_uv();
    rd(a_one, 32'h04);
    apb(1'b1, a_one, 32'h0C);
    cyc(1);
    chk(undervolt_detect_active, 1'b1);
    pulse_uv();
    rd(a_one, 32'h8C);
    stop_mode_active <= 1'b0;
    // Sticky warning, clear refused while present; this first write of
    // control two also takes the write-once selects
    supply_warning_present <= 1'b1;
    cyc(4);
    rd(a_two, 32'h80);
    apb(1'b1, a_two, 32'h71);
    rd(a_two, 32'hB1);
    chk({undervolt_trip_select, warning_trip_select}, 2'b11);
    chk(deep_stop_select, 1'b1);
    supply_warning_present <= 1'b0;
    cyc(4);
    rd(a_two, 32'hB1);
    apb(1'b1, a_two, 32'h40);
    rd(a_two, 32'h21);
    // Write-once selects and survival of a non-power-on reset
    apb(1'b1, a_two, 32'h00);
    rd(a_two, 32'h21);
    apb(1'b1, a_two, 32'h10);
    supply_warning_present <= 1'b1;
    sys_reset_pulse <= 1'b1;
    cyc(1);
    sys_reset_pulse <= 1'b0;
    cyc(4);
    rd(a_two, 32'hB0);
    supply_warning_present <= 1'b0;
    cyc(4);
    apb(1'b1, a_two, 32'h41);
    rd(a_two, 32'h21);
    pstrb <= 4'hE;
    apb(1'b1, a_two, 32'h10);
    pstrb <= 4'hF;
    rd(a_two, 32'h21);
    deep_stop_exit_pulse <= 1'b1;
    cyc(1);
    deep_stop_exit_pulse <= 1'b0;
    cyc(2);
    rd(a_two, 32'h29);
    apb(1'b1, a_two, 32'h04);
    rd(a_two, 32'h21);
    // System options and timer clock routing with random pins
    apb(1'b1, a_opt, 32'h88);
    chk(watchdog_bus_clock_select, 1'b1);
    apb(1'b1, a_opt, 32'h00);
    rd(a_opt, 32'h80);
    for (int k = 0; k < 12; k++)
    begin
      if (k == 6)
        apb(1'b1, a_opt, 32'h08);
      v = $urandom;
      {timer_one_ext_clock, shared_timer_ext_clock} <= v[1:0];
      timer_two_ext_clock <= v[2];
      cyc(4);
      chk(timer_clock_routing, k >= 6);
      chk(timer_ext_clock, exp_tmr(k >= 6, v[0], v[1], v[2]));
    end
    for (int k = 0; k < 8; k++)
    begin
      v = $urandom & 32'hFD;
      apb(1'b1, a_one, v);
      rd(a_one, v & 32'h3D);
      chk(reference_buffer_enable, v[0]);
    end
    give_verdict();
  end
endmodule : pmsc_top_tb
